// [include/ecpct_pkg.sv]
// Package of constants, register map and types for the eight-channel pulse counter/timer.
//
// Contract
// RL1: Any data read pauses all counting and the timer for 120 ns before latching; the code pauses only data reads made while a run is active.
// RL2: One channel or all, every counter and the timer pause together, same length.
// RL3: Once a timer-stop or counter-stop run has ended, reads cause no pause.
// RL4: Only this unit pauses on its own reads; linked units keep counting.
// RL5: Counters are 32 bits; overflow is flagged and reads report it.
// RL6: Eight channels 0 to 7; channel 7 is the preset counter.
// RL7: One 40-bit elapsed timer advancing once per microsecond.
// RL8: Timer preset from one to 40-bit maximum, in microseconds or milliseconds.
// RL9: Count preset on channel 7 from one upward, in counts or thousands.
// RL10: Single mode: start trigger or command begins a run ending at enabled preset.
// RL11: Stop trigger or stop command ends the run at once.
// RL12: With both preset stops disabled, counting runs until a stop arrives.
// RL13: Gate acquisition stores all totals and timer on each gate off, up to 10000.
// RL14: Clock acquisition stores all totals on each sync clock off, up to 10000.
// RL15: The gate source keeps each on-plus-off gate period above 10 ms; the bench's ecpct_src gives gate periods of a few cycles.
// RL16: The sync clock source keeps each run-plus-off period above 10 ms; the bench's ecpct_src gives sync periods of a few cycles.
// RL17: Gate high enables all channels and timer; polarity is invertible.
// RL18: A counting-active output shows a run in progress; polarity is invertible.
// RL19: Start and stop inputs act on rising edges, each edge invertible.
// RL20: With auto halt disabled, presets never end a run; only gate and stop rule.
// RL21: A channel's overflow flag stays set until that channel is cleared.
package ecpct_pkg;

  // Clock and timing.
  localparam int CLK_MHZ = 200;
  localparam int PAUSE_NS = 120;
  localparam int PAUSE_CYC = (PAUSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] PAUSE_LAST = 5'(PAUSE_CYC - 1);
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS * CLK_MHZ / 1000;
  localparam logic [7:0] US_LAST = 8'(US_CYC - 1);

  // Sizes.
  localparam int NCH = 8;
  localparam int CW = 32;
  localparam int TW = 40;
  localparam int PRESET_CH = 7;
  localparam int MAX_REC = 10000;
  localparam int REC_WORDS = 10;
  localparam int STORE_DEPTH = MAX_REC * REC_WORDS;
  localparam int SAW = 17;
  localparam int RCW = 14;
  localparam int UNIT_SCALE = 1000;
  localparam logic [RCW-1:0] REC_LIMIT = 14'(MAX_REC);
  localparam logic [3:0] REC_LAST_WORD = 4'(REC_WORDS - 1);
  localparam logic [CW-1:0] CNT_MAX = 32'hFFFFFFFF;
  localparam logic [TW-1:0] TIM_MAX = 40'hFFFFFFFFFF;
  localparam logic [CW-1:0] OVER_WORD = 32'hFFFFFFFF;

  // Register byte offsets.
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_CMD = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_TPRE_LO = 12'h00C;
  localparam logic [11:0] A_TPRE_HI = 12'h010;
  localparam logic [11:0] A_CPRE = 12'h014;
  localparam logic [11:0] A_REC_CNT = 12'h018;
  localparam logic [11:0] A_REC_ADDR = 12'h01C;
  localparam logic [11:0] A_REC_DATA = 12'h020;
  localparam logic [11:0] A_CNT0 = 12'h040;
  localparam logic [11:0] A_TIM_LO = 12'h060;
  localparam logic [11:0] A_TIM_HI = 12'h064;

  // Control register fields.
  localparam int C_MODE = 0;
  localparam int C_TSTOP_EN = 2;
  localparam int C_CSTOP_EN = 3;
  localparam int C_AUTO_HALT_DIS = 4;
  localparam int C_GATE_INV = 5;
  localparam int C_RUN_INV = 6;
  localparam int C_START_INV = 7;
  localparam int C_STOP_INV = 8;
  localparam int C_TUNIT_MS = 9;
  localparam int C_CUNIT_K = 10;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h000007FF;

  // Command register bits, each a one-shot action.
  localparam int K_BEGIN = 0;
  localparam int K_STOP = 1;
  localparam int K_CLR_ALL = 2;
  localparam int K_CLR_TIM = 3;
  localparam int K_CLR_PRESET = 4;
  localparam int K_CLR_REC = 5;
  localparam int K_CLR_CH = 8;

  // Status register fields.
  localparam int S_RUN = 0;
  localparam int S_FULL = 1;
  localparam int S_BUSY = 2;
  localparam int S_OVF = 8;

  localparam logic [31:0] TPRE_RST = 32'h00000001;
  localparam logic [31:0] CPRE_RST = 32'h00000001;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_GATE_ACQ = 2'b01,
    MODE_CLK_ACQ = 2'b10
  } ecpct_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_PAUSE = 2'b01,
    PH_ANSWER = 2'b11
  } ecpct_phase_t;

  typedef struct packed {
    logic [TW-1:0] timer;
    logic [NCH-1:0][CW-1:0] count;
  } ecpct_record_t;

  typedef struct packed {
    ecpct_phase_t ph;
    logic [4:0] pcnt;
    logic [31:0] prdata;
    logic slverr;
    logic [31:0] ctrl;
    logic [31:0] tpre_lo;
    logic [7:0] tpre_hi;
    logic [31:0] cpre;
    logic [SAW-1:0] rec_addr;
    logic run;
    logic [7:0] us_div;
    logic [TW-1:0] timer;
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0] ovf;
    logic [NCH-1:0] pulse_prev;
    logic gate_prev;
    logic sync_prev;
    logic start_prev;
    logic stop_prev;
    logic run_out;
  } ecpct_top_state_t;

  typedef struct packed {
    logic busy;
    logic [3:0] word;
    ecpct_record_t rec;
    logic [RCW-1:0] count;
    logic full;
    logic [31:0] rd_data;
  } ecpct_store_state_t;

endpackage

// [logic/ecpct_store.sv]
// Record store that keeps acquisition snapshots as ten 32-bit words each.
module ecpct_store
  import ecpct_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cap,
  input wire ecpct_record_t rec,
  input wire logic clr,
  input wire logic [SAW-1:0] rd_addr,
  output logic [31:0] rd_data,
  output logic [RCW-1:0] rec_count,
  output logic full,
  output logic busy
);

  ecpct_store_state_t q;
  ecpct_store_state_t d;
  logic [31:0] mem [STORE_DEPTH];
  logic [SAW-1:0] wr_addr;
  logic wr_en;

  // Picks one word of a record: channels first, then timer low and high.
  function automatic logic [31:0] rec_word(ecpct_record_t r, logic [3:0] w);
    logic [31:0] v;
    v = 32'h00000000;
    if (w < 4'(NCH)) begin
      v = r.count[w[2:0]];
    end else if (w == 4'(NCH)) begin
      v = r.timer[31:0];
    end else begin
      v = {24'h000000, r.timer[TW-1:32]};
    end
    return v;
  endfunction

  // A snapshot is copied at once, then written one word a cycle; the slow
  // gate or clock period leaves ample time, so a capture while busy is dropped.
  always_comb begin
    d = q;
    wr_en = 1'b0;
    wr_addr = SAW'(q.count * REC_WORDS) + SAW'(q.word);
    if (q.busy) begin
      wr_en = 1'b1;
      if (q.word == REC_LAST_WORD) begin
        d.busy = 1'b0;
        d.word = 4'h0;
        d.count = q.count + 14'h0001;
        d.full = (q.count + 14'h0001) == REC_LIMIT; // RL13
      end else begin
        d.word = q.word + 4'h1;
      end
    end else if (cap && !q.full) begin
      d.busy = 1'b1;
      d.word = 4'h0;
      d.rec = rec;
    end
    if (clr) begin
      d.busy = 1'b0;
      d.word = 4'h0;
      d.count = '0;
      // A record that fills the store in the clear cycle still sets the flag.
      d.full = d.full && !q.full;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Memory has no reset; its read port is a plain registered read.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= rec_word(q.rec, q.word);
    end
    if (rd_addr < SAW'(STORE_DEPTH)) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 32'h00000000;
    end
  end

  assign rec_count = q.count;
  assign full = q.full;
  assign busy = q.busy;

endmodule

// [logic/ecpct_top.sv]
// Eight-channel pulse counter with microsecond timer, presets, acquisition and APB registers.
//
// The placing of the registers and register access over APB were left to the implementer.
module ecpct_top
  import ecpct_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] pulse_in,
  input wire logic gate_in,
  input wire logic sync_clk_in,
  input wire logic start_in,
  input wire logic stop_in,
  output logic run_out
);

  ecpct_top_state_t q;
  ecpct_top_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True for the addresses whose reading must freeze the counters first.
  function automatic logic is_data(logic [11:0] a);
    return (a[11:5] == A_CNT0[11:5]) || (a == A_TIM_LO) || (a == A_TIM_HI);
  endfunction

  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Record store.

  ecpct_record_t snap;
  logic cap;
  logic rec_clr;
  logic [31:0] store_rd;
  logic [RCW-1:0] rec_count;
  logic store_full;
  logic store_busy;

  // A record holds the totals as they stand before this cycle's update.
  assign snap.timer = q.timer;
  assign snap.count = q.cnt;

  ecpct_store u_store (
    .clk(clk),
    .resetn(resetn),
    .cap(cap),
    .rec(snap),
    .clr(rec_clr),
    .rd_addr(q.rec_addr),
    .rd_data(store_rd),
    .rec_count(rec_count),
    .full(store_full),
    .busy(store_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  logic [31:0] rd_val;
  logic mapped;

  // An overflowed channel reads as the overflow word, not a stale value.
  always_comb begin
    rd_val = 32'h00000000;
    mapped = 1'b1;
    if (paddr == A_CTRL) begin
      rd_val = q.ctrl;
    end else if (paddr == A_CMD) begin
      rd_val = 32'h00000000;
    end else if (paddr == A_STAT) begin
      rd_val[S_RUN] = q.run;
      rd_val[S_FULL] = store_full;
      rd_val[S_BUSY] = store_busy;
      rd_val[S_OVF +: NCH] = q.ovf;
    end else if (paddr == A_TPRE_LO) begin
      rd_val = q.tpre_lo;
    end else if (paddr == A_TPRE_HI) begin
      rd_val = {24'h000000, q.tpre_hi};
    end else if (paddr == A_CPRE) begin
      rd_val = q.cpre;
    end else if (paddr == A_REC_CNT) begin
      rd_val = {18'h00000, rec_count};
    end else if (paddr == A_REC_ADDR) begin
      rd_val = {15'h0000, q.rec_addr};
    end else if (paddr == A_REC_DATA) begin
      rd_val = store_rd;
    end else if (paddr[11:5] == A_CNT0[11:5]) begin
      rd_val = q.ovf[paddr[4:2]] ? OVER_WORD : q.cnt[paddr[4:2]]; // RL5
    end else if (paddr == A_TIM_LO) begin
      rd_val = q.timer[31:0];
    end else if (paddr == A_TIM_HI) begin
      rd_val = {24'h000000, q.timer[TW-1:32]};
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic gate_lvl;
  logic start_lvl;
  logic stop_lvl;
  logic start_ev;
  logic stop_ev;
  logic acc;
  logic wr_now;
  logic pause;
  logic en;
  logic t_hit;
  logic c_hit;
  logic [31:0] cmd;
  logic [49:0] t_pre;
  logic [49:0] t_tgt;
  logic [41:0] c_tgt;
  logic [31:0] ra_merged;

  always_comb begin
    d = q;
    cap = 1'b0;
    rec_clr = 1'b0;

    // Control inputs with their polarity options.
    gate_lvl = gate_in ^ q.ctrl[C_GATE_INV]; // RL17
    start_lvl = start_in ^ q.ctrl[C_START_INV]; // RL19
    stop_lvl = stop_in ^ q.ctrl[C_STOP_INV]; // RL19
    start_ev = start_lvl && !q.start_prev; // RL19
    stop_ev = stop_lvl && !q.stop_prev; // RL19
    d.gate_prev = gate_lvl;
    d.start_prev = start_lvl;
    d.stop_prev = stop_lvl;
    d.sync_prev = sync_clk_in;
    d.pulse_prev = pulse_in;

    // Bus phases: writes land on the cycle that shows pready.
    acc = psel && penable;
    wr_now = acc && pwrite && (q.ph == PH_ANSWER);
    cmd = (wr_now && paddr == A_CMD) ? pwdata : 32'h00000000;

    // A data read while running freezes all counters and the timer for the fixed pause; once
    // the run has ended the values are still, so the read answers at once.
    case (q.ph)
      PH_IDLE: begin
        if (acc) begin
          if (!pwrite && is_data(paddr) && q.run) begin // RL3
            d.ph = PH_PAUSE; // RL1
            d.pcnt = PAUSE_LAST; // RL2
          end else begin
            d.ph = PH_ANSWER;
            d.prdata = pwrite ? 32'h00000000 : rd_val;
            d.slverr = !mapped;
          end
        end
      end
      PH_PAUSE: begin
        if (q.pcnt == 5'h00) begin
          d.ph = PH_ANSWER;
          d.prdata = rd_val; // RL1
          d.slverr = 1'b0;
        end else begin
          d.pcnt = q.pcnt - 5'h01;
        end
      end
      PH_ANSWER: begin
        d.ph = PH_IDLE;
        d.slverr = 1'b0;
      end
      default: begin
        d.ph = PH_IDLE;
      end
    endcase

    // Register writes; the record address is merged as a full word, then cut to its width.
    ra_merged = wmerge({15'h0000, q.rec_addr}, pwdata, pstrb);
    if (wr_now) begin
      if (paddr == A_CTRL) begin
        d.ctrl = wmerge(q.ctrl, pwdata, pstrb) & CTRL_MASK;
      end else if (paddr == A_TPRE_LO) begin
        d.tpre_lo = wmerge(q.tpre_lo, pwdata, pstrb); // RL8
      end else if (paddr == A_TPRE_HI) begin
        d.tpre_hi = pstrb[0] ? pwdata[7:0] : q.tpre_hi; // RL8
      end else if (paddr == A_CPRE) begin
        d.cpre = wmerge(q.cpre, pwdata, pstrb); // RL9
      end else if (paddr == A_REC_ADDR) begin
        d.rec_addr = ra_merged[SAW-1:0];
      end
    end

    // The pause is this unit's own; a linked unit sees no change on run_out.
    pause = (q.ph == PH_PAUSE); // RL4
    en = q.run && gate_lvl && !pause; // RL17

    // Microsecond tick from the divider, then the timer.
    if (en) begin
      if (q.us_div == US_LAST) begin
        d.us_div = 8'h00;
        if (q.timer != TIM_MAX) begin
          d.timer = q.timer + 40'h0000000001; // RL7
        end
      end else begin
        d.us_div = q.us_div + 8'h01;
      end
    end

    // Channel counters; pulses seen during the pause are lost by design.
    for (int i = 0; i < NCH; i++) begin
      if (en && pulse_in[i] && !q.pulse_prev[i]) begin
        if (q.cnt[i] == CNT_MAX) begin
          d.ovf[i] = 1'b1; // RL5
        end else begin
          d.cnt[i] = q.cnt[i] + 32'h00000001; // RL6
        end
      end
    end

    // Clears; the overflow flag only drops with its channel.
    for (int i = 0; i < NCH; i++) begin
      if (cmd[K_CLR_CH + i] || cmd[K_CLR_ALL] || (i == PRESET_CH && cmd[K_CLR_PRESET])) begin
        d.cnt[i] = 32'h00000000;
        // An overflow that lands in the clear cycle still sets the flag, so it is never lost.
        d.ovf[i] = en && pulse_in[i] && !q.pulse_prev[i] && (q.cnt[i] == CNT_MAX); // RL21
      end
    end
    if (cmd[K_CLR_TIM] || cmd[K_CLR_ALL]) begin
      d.timer = 40'h0000000000;
      d.us_div = 8'h00;
    end
    rec_clr = cmd[K_CLR_REC];

    // Preset targets; the millisecond and kilocount units scale by a thousand.
    t_pre = {10'h000, q.tpre_hi, q.tpre_lo};
    t_tgt = q.ctrl[C_TUNIT_MS] ? 50'(t_pre * UNIT_SCALE) : t_pre; // RL8
    c_tgt = q.ctrl[C_CUNIT_K] ? 42'({10'h000, q.cpre} * UNIT_SCALE) : {10'h000, q.cpre}; // RL9
    t_hit = {10'h000, q.timer} >= t_tgt;
    c_hit = q.ovf[PRESET_CH] || ({10'h000, q.cnt[PRESET_CH]} >= c_tgt); // RL6

    // Run control: begin, then preset stops, then an explicit stop wins.
    if (start_ev || cmd[K_BEGIN]) begin
      d.run = 1'b1; // RL10
    end
    if (q.run && !q.ctrl[C_AUTO_HALT_DIS]) begin // RL20
      if ((q.ctrl[C_TSTOP_EN] && t_hit) || (q.ctrl[C_CSTOP_EN] && c_hit)) begin // RL12
        d.run = 1'b0; // RL10
      end
    end
    if (stop_ev || cmd[K_STOP]) begin
      d.run = 1'b0; // RL11
    end

    // Acquisition on the falling edge of the gate or of the sync clock.
    if (q.run) begin
      if (q.ctrl[C_MODE +: 2] == MODE_GATE_ACQ && q.gate_prev && !gate_lvl) begin
        cap = 1'b1; // RL13
      end else if (q.ctrl[C_MODE +: 2] == MODE_CLK_ACQ && q.sync_prev && !sync_clk_in) begin
        cap = 1'b1; // RL14
      end
    end

    d.run_out = d.run ^ d.ctrl[C_RUN_INV]; // RL18
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.tpre_lo <= TPRE_RST;
      q.cpre <= CPRE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = (q.ph == PH_ANSWER);
  assign pslverr = (q.ph == PH_ANSWER) && q.slverr;
  assign run_out = q.run_out;

endmodule

// [verif/ecpct_src.sv]
// Model of the pulse sources, gate driver and sync clock in front of the counter.
module ecpct_src
  import ecpct_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic gate_req,
  output logic [NCH-1:0] pulse_in,
  output logic gate_in,
  output logic sync_clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] left_q;
  ////////////////////////////////////////////////////////////////
  // One cycle high then one low, so a clock-sampled edge detector sees every pulse.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_q <= '0;
      pulse_in <= '0;
    end else if (go) begin
      left_q <= {n, 1'b0};
    end else if (left_q != 9'h000) begin
      left_q <= left_q - 9'h001;
      pulse_in <= {NCH{~left_q[0]}};
    end else begin
      pulse_in <= '0;
    end
  end
  // The gate follows gate_req directly, so it can fall during a run and make a short acquisition period.
  assign gate_in = gate_req;
  // The sync clock follows the same request, so its periods are as short as the bench drives, down to two cycles high.
  assign sync_clk_in = gate_req;
endmodule

// [verif/ecpct_monitor.sv]
// Checker of bus answer timing and run control, seen from the top module's ports.
module ecpct_monitor
  import ecpct_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] pulse_in,
  input wire logic gate_in,
  input wire logic sync_clk_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic run_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl_q;
  logic wr, run, dat, cmdw, nohalt;
  ////////////////////////////////////////////////////////////////
  // Shadow of the control word, so polarity and stop settings are known here.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= '0;
    end else if (wr && paddr == A_CTRL) begin
      ctrl_q <= pwdata & CTRL_MASK;
    end
  end
  // Decoded views of the bus and of the run state.
  assign wr = psel && penable && pready && pwrite;
  assign run = run_out ^ ctrl_q[C_RUN_INV];
  // Only reads of counters or timer pause; writes there answer at once.
  assign dat = !pwrite && (paddr[11:5] == A_CNT0[11:5] || paddr == A_TIM_LO || paddr == A_TIM_HI);
  assign cmdw = wr && paddr == A_CMD;
  assign nohalt = ctrl_q[3:2] == 2'b00 || ctrl_q[C_AUTO_HALT_DIS];
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pause_length_a: assert property (psel && $rose(penable) && dat && run |-> ##25 pready)
    else $error("Running data read not answered after the pause.");
  pause_quiet_a: assert property (psel && $rose(penable) && dat && run |=> (!pready)[*8])
    else $error("Running data read answered before the pause ended.");
  no_dead_time_a: assert property (psel && $rose(penable) && !(dat && run) |-> ##1 pready)
    else $error("Read without a run was delayed.");
  answer_once_a: assert property (pready |=> !pready)
    else $error("Bus answer held longer than one cycle.");
  stop_pin_a: assert property ($rose(stop_in ^ ctrl_q[C_STOP_INV]) && !psel |=> !run)
    else $error("Stop input edge did not end the run.");
  stop_cmd_a: assert property (cmdw && pwdata[K_STOP] |=> !run)
    else $error("Stop command did not end the run.");
  begin_cmd_a: assert property (cmdw && pwdata[K_BEGIN] && !pwdata[K_STOP] && ctrl_q[3:2] == 2'b00
    && !$rose(stop_in ^ ctrl_q[C_STOP_INV]) |=> run)
    else $error("Begin command did not start a run.");
  start_pin_a: assert property ($rose(start_in ^ ctrl_q[C_START_INV]) && ctrl_q[3:2] == 2'b00 && !wr
    && !$rose(stop_in ^ ctrl_q[C_STOP_INV]) |=> run)
    else $error("Start input edge did not start a run.");
  run_hold_a: assert property (run && nohalt && !wr && !$rose(stop_in ^ ctrl_q[C_STOP_INV]) |=> run)
    else $error("Run ended with no stop and no preset halt.");
endmodule
bind ecpct_top ecpct_monitor u_mon (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .pulse_in, .gate_in, .sync_clk_in, .start_in, .stop_in, .run_out);

// [verif/ecpct_tb_top.sv]
// Self-checking bench for the pulse counter/timer over its register bus and pins.
module ecpct_tb_top
  import ecpct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic gate_req = 1, start_in = 0, stop_in = 0, pready, pslverr, run_out, gate_in, sync_clk_in, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] n = '0;
  logic [NCH-1:0] pulse_in;
  int err_total = 0, n_compared = 0;
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk = ~clk;
  end
  ecpct_top DUT (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pulse_in, .gate_in, .sync_clk_in, .start_in, .stop_in, .run_out);
  ecpct_src SRC (.clk, .resetn, .go, .n, .gate_req, .pulse_in, .gate_in, .sync_clk_in);
  ////////////////////////////////////////////////////////////////
  // One bus transfer, entered just after an edge; the slave sets the pace.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && k++ < 200);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[ERR] pready exp 1 got %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    cmp(nm, x, r);
  endtask
  // A burst of k pulses on every channel, then a short settle.
  task automatic burst(input logic [7:0] k);
    go <= 1;
    n <= k;
    @(posedge clk);
    go <= 0;
    repeat (2 * k + 4) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard of 20000 cycles, far beyond the under one thousand cycles the tests need.
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    chk("ctrl", A_CTRL, CTRL_RST);
    chk("tpre_lo", A_TPRE_LO, TPRE_RST);
    chk("cpre", A_CPRE, CPRE_RST);
    chk("stat", A_STAT, 32'h0);
    xfer(1'b0, 12'h030, 32'h0);
    cmp("unmapped_err", 32'h1, {31'h0, e});
    $display("test reset done");
    wr(A_CMD, 32'h1);
    cmp("run_out", 32'h1, {31'h0, run_out});
    chk("cnt0_run", A_CNT0, 32'h0);
    burst(8'h03);
    wr(A_CMD, 32'h2);
    for (int c = 0; c < NCH; c++) chk("cnt", A_CNT0 + 12'(4 * c), 32'h3);
    $display("test count done");
    // Gate closed holds counts; inverted gate reopens them.
    gate_req <= 0;
    wr(A_CMD, 32'h4);
    wr(A_CMD, 32'h1);
    burst(8'h03);
    wr(A_CMD, 32'h2);
    chk("cnt0_gate", A_CNT0, 32'h0);
    wr(A_CTRL, 32'h1 << C_GATE_INV);
    wr(A_CMD, 32'h1);
    burst(8'h02);
    wr(A_CMD, 32'h2);
    chk("cnt0_inv", A_CNT0, 32'h2);
    gate_req <= 1;
    $display("test gate done");
    // Count preset on the preset channel ends the run for all channels.
    wr(A_CPRE, 32'h5);
    wr(A_CTRL, 32'h1 << C_CSTOP_EN);
    wr(A_CMD, 32'h4);
    wr(A_CMD, 32'h1);
    burst(8'h08);
    chk("stat", A_STAT, 32'h0);
    chk("cnt7", A_CNT0 + 12'h01C, 32'h5);
    chk("cnt0", A_CNT0, 32'h5);
    wr(A_CMD, 32'h00000110);
    chk("cnt7_clr", A_CNT0 + 12'h01C, 32'h0);
    chk("cnt0_clr", A_CNT0, 32'h0);
    chk("cnt1", A_CNT0 + 12'h004, 32'h5);
    $display("test count preset done");
    // Auto halt disabled: only the stop input ends the run.
    wr(A_CTRL, (32'h1 << C_CSTOP_EN) | (32'h1 << C_AUTO_HALT_DIS));
    wr(A_CMD, 32'h4);
    wr(A_CMD, 32'h1);
    burst(8'h08);
    chk("stat", A_STAT, 32'h1);
    stop_in <= 1;
    repeat (2) @(posedge clk);
    stop_in <= 0;
    chk("stat", A_STAT, 32'h0);
    chk("cnt7", A_CNT0 + 12'h01C, 32'h8);
    $display("test auto halt done");
    // Timer preset of two microseconds.
    wr(A_TPRE_LO, 32'h2);
    wr(A_CTRL, 32'h1 << C_TSTOP_EN);
    wr(A_CMD, 32'h4);
    wr(A_CMD, 32'h1);
    for (int k = 0; k < 300; k++) begin
      xfer(1'b0, A_STAT, 32'h0);
      if (r[S_RUN] === 1'b0) break;
    end
    cmp("run", 32'h0, {31'h0, r[S_RUN]});
    chk("tim_lo", A_TIM_LO, 32'h2);
    chk("tim_hi", A_TIM_HI, 32'h0);
    $display("test timer preset done");
    // Start input on its rising edge, then on its inverted edge.
    wr(A_CTRL, 32'h0);
    start_in <= 1;
    repeat (2) @(posedge clk);
    cmp("run_out", 32'h1, {31'h0, run_out});
    wr(A_CMD, 32'h2);
    wr(A_CTRL, 32'h1 << C_START_INV);
    start_in <= 0;
    repeat (2) @(posedge clk);
    cmp("run_out", 32'h1, {31'h0, run_out});
    wr(A_CMD, 32'h2);
    cmp("run_out", 32'h0, {31'h0, run_out});
    wr(A_CTRL, 32'h1 << C_RUN_INV);
    cmp("run_out_inv", 32'h1, {31'h0, run_out});
    $display("test pins done");
    // Gate acquisition on the gate's fall, then clock acquisition on the sync clock's fall.
    wr(A_CTRL, 32'h1);
    wr(A_CMD, 32'h24);
    wr(A_CMD, 32'h1);
    burst(8'h02);
    gate_req <= 0;
    repeat (12) @(posedge clk);
    chk("rec_cnt", A_REC_CNT, 32'h1);
    wr(A_CTRL, 32'h2 | (32'h1 << C_GATE_INV));
    gate_req <= 1;
    repeat (2) @(posedge clk);
    gate_req <= 0;
    repeat (12) @(posedge clk);
    wr(A_CMD, 32'h2);
    chk("rec_cnt", A_REC_CNT, 32'h2);
    wr(A_REC_ADDR, 32'h00000000);
    chk("rec_data0", A_REC_DATA, 32'h2);
    wr(A_REC_ADDR, 32'h0000000A);
    chk("rec_data1", A_REC_DATA, 32'h2);
    gate_req <= 1;
    $display("test acquisition done");
    report_and_stop;
  end
endmodule
